// ==== an_np_mmd_map.svh ====
// Purpose: register offsets, field positions and reset values
// Assumes: 16-bit management registers, 5-bit register index
// Notes:   definitions only
`ifndef AN_NP_MMD_MAP_SVH
`define AN_NP_MMD_MAP_SVH
// ****************************************************************
// offsets
// ****************************************************************
`define REG_AN_EXPANSION   5'h06
`define REG_LOCAL_NP_TX    5'h07
`define REG_PARTNER_NP_RX  5'h08
`define REG_INDIRECT_CTRL  5'h0D
`define REG_INDIRECT_DATA  5'h0E
// ****************************************************************
// fields
// ****************************************************************
`define EXP_PD_FAULT_BIT   4
`define EXP_LP_NP_BIT      3
`define EXP_NP_ABLE_BIT    2
`define EXP_PAGE_RX_BIT    1
`define EXP_LP_AN_BIT      0
`define NP_NEXT_BIT        15
`define NP_MSG_PAGE_BIT    13
`define NP_COMPLY_BIT      12
`define NP_TOGGLE_BIT      11
`define NP_ACK_BIT         14
`define CTRL_OP_HI         15
`define CTRL_OP_LO         14
`define CTRL_DEV_HI        4
`define CTRL_DEV_LO        0
// ****************************************************************
// reset values
// ****************************************************************
`define NP_TX_RESET        16'h2001
`define CTRL_RESET         16'h0000
`define INDIRECT_RESET     16'h0000
`define NP_ABLE_RESET      1'b1
`endif

// ==== an_np_mmd_pkg.sv ====
// Purpose: shared types for the next-page and indirect access block
// Assumes: nothing
// Notes:   offsets live in the map header
package an_np_mmd_pkg;
  typedef enum logic [1:0] {
    OP_ADDRESS     = 2'b00,
    OP_DATA_NOINC  = 2'b01,
    OP_DATA_INC_RW = 2'b10,
    OP_DATA_INC_WR = 2'b11
  } mmd_op_e;
  typedef logic [15:0] word_t;
endpackage

// ==== mgmt_if.sv ====
// Purpose: management register port between controller and transceiver
// Assumes: one clock, synchronous accesses
// Notes:   read data valid one cycle after the read strobe
`timescale 1ns/1ps
interface mgmt_if;
  logic        wr;
  logic        rd;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport device (input wr, input rd, input addr, input wdata, output rdata);
  modport station (output wr, output rd, output addr, output wdata, input rdata);
endinterface

// ==== an_np_mmd_regs.sv ====
// Purpose: expansion, next-page and indirect access registers
// Assumes: management accesses are one-cycle strobes
// Notes:   indirect space reached through an external port
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "an_np_mmd_map.svh"
module an_np_mmd_regs
  import an_np_mmd_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // management port
  mgmt_if.device           mgmt,
  // autoneg status from the negotiation engine
  input  wire logic        i_pd_fault,
  input  wire logic        i_partner_np_able,
  input  wire logic        i_local_np_able,
  input  wire logic        i_page_received,
  input  wire logic        i_partner_an_able,
  input  wire logic        i_tx_toggle,
  input  wire logic [15:0] i_partner_page,
  // next page to transmit
  output logic      [15:0] o_tx_page,
  // indirect device space
  output logic      [4:0]  o_mmd_dev,
  output logic      [15:0] o_mmd_addr,
  output logic      [15:0] o_mmd_wdata,
  output logic             o_mmd_wr,
  output logic             o_mmd_rd,
  input  wire logic [15:0] i_mmd_rdata
);
  logic        pd_fault;
  logic        page_rx;
  logic [15:0] np_tx;
  logic        prev_toggle;
  logic [15:0] ctrl;
  logic [15:0] mmd_addr;
  logic [15:0] rdata;
  mmd_op_e     op;
  logic        data_wr;
  logic        data_rd;
  logic        bump;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    return a == r;
  endfunction

  assign op      = mmd_op_e'(ctrl[`CTRL_OP_HI:`CTRL_OP_LO]);
  assign data_wr = mgmt.wr && hit(mgmt.addr, `REG_INDIRECT_DATA) && op != OP_ADDRESS;
  assign data_rd = mgmt.rd && hit(mgmt.addr, `REG_INDIRECT_DATA) && op != OP_ADDRESS;
  always_comb begin
    unique case (op)
      OP_ADDRESS:     bump = 1'b0;
      OP_DATA_NOINC:  bump = 1'b0;
      OP_DATA_INC_RW: bump = data_wr || data_rd;
      OP_DATA_INC_WR: bump = data_wr;
    endcase
  end

  // ****************************************************************
  // latched expansion status
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pd_fault <= 1'b0;
      page_rx  <= 1'b0;
    end else begin
      // set wins over the clear-on-read
      if (i_pd_fault)
        pd_fault <= 1'b1;
      else if (mgmt.rd && hit(mgmt.addr, `REG_AN_EXPANSION))
        pd_fault <= 1'b0;
      if (i_page_received)
        page_rx <= 1'b1;
      else if (mgmt.rd && hit(mgmt.addr, `REG_AN_EXPANSION))
        page_rx <= 1'b0;
    end
  end

  // ****************************************************************
  // local next page
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      np_tx <= `NP_TX_RESET;
    end else if (mgmt.wr && hit(mgmt.addr, `REG_LOCAL_NP_TX)) begin
      // reserved 7.14 and toggle 7.11 not writable
      np_tx <= mgmt.wdata & 16'hB7FF;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      prev_toggle <= 1'b0;
    else
      prev_toggle <= i_tx_toggle;
  end

  always_comb begin
    o_tx_page = np_tx;
    o_tx_page[`NP_TOGGLE_BIT] = prev_toggle;
  end

  // ****************************************************************
  // indirect access
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl <= `CTRL_RESET;
    end else if (mgmt.wr && hit(mgmt.addr, `REG_INDIRECT_CTRL)) begin
      ctrl <= mgmt.wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      mmd_addr <= `INDIRECT_RESET;
    else if (mgmt.wr && hit(mgmt.addr, `REG_INDIRECT_DATA) && op == OP_ADDRESS)
      mmd_addr <= mgmt.wdata;
    else if (bump)
      mmd_addr <= mmd_addr + 16'h0001;
  end

  assign o_mmd_dev   = ctrl[`CTRL_DEV_HI:`CTRL_DEV_LO];
  assign o_mmd_addr  = mmd_addr;
  assign o_mmd_wdata = mgmt.wdata;
  assign o_mmd_wr    = data_wr;
  assign o_mmd_rd    = data_rd;

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata <= 16'h0000;
    end else if (mgmt.rd) begin
      unique case (mgmt.addr)
        `REG_AN_EXPANSION: begin
          rdata <= {11'h000, pd_fault | i_pd_fault, i_partner_np_able,
                    i_local_np_able, page_rx | i_page_received,
                    i_partner_an_able};
        end
        `REG_LOCAL_NP_TX:   rdata <= o_tx_page;
        `REG_PARTNER_NP_RX: begin
          rdata <= {i_partner_page[15:12], ~prev_toggle,
                    i_partner_page[10:0]};
        end
        `REG_INDIRECT_CTRL: rdata <= ctrl;
        `REG_INDIRECT_DATA: rdata <= (op == OP_ADDRESS) ? mmd_addr : i_mmd_rdata;
        default:            rdata <= 16'h0000;
      endcase
    end
  end
  assign mgmt.rdata = rdata;
endmodule

// ==== an_np_mmd_station.sv ====
// Purpose: station controller end driving the management registers
// Assumes: user issues one command at a time
// Notes:   passes user write strobe through, read strobe only without write, captures read data
`timescale 1ns/1ps
module an_np_mmd_station (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // user command
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  // user answer
  output logic      [15:0] o_rdata,
  output logic             o_rvalid,
  // management port
  mgmt_if.station          mgmt
);
  logic [15:0] rdata;
  logic        rd_d;
  logic        rvalid;

  assign mgmt.wr    = i_wr;
  assign mgmt.rd    = i_rd && !i_wr;
  assign mgmt.addr  = i_addr;
  assign mgmt.wdata = i_wdata;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      rd_d <= 1'b0;
    else
      rd_d <= i_rd && !i_wr;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      rdata <= 16'h0000;
    else if (rd_d)
      rdata <= mgmt.rdata;
  end

  // valid lines up with the captured word, not with the capture strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n)
      rvalid <= 1'b0;
    else
      rvalid <= rd_d;
  end

  assign o_rdata  = rdata;
  assign o_rvalid = rvalid;
endmodule

// ==== an_np_mmd_sva.sv ====
// Purpose: checks on the management port
// Assumes: one clock, sync reset
// Notes:   sees interface signals only
`timescale 1ns/1ps
module an_np_mmd_sva (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  // management port
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // ****
  // written-since-reset flags
  // ****
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic w7;
  logic wd;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      w7 <= 1'b0;
      wd <= 1'b0;
    end else begin
      w7 <= w7 | (wr && addr == 5'h07);
      wd <= wd | (wr && addr == 5'h0D);
    end
  end
  sequence s_wr_rd(logic [4:0] a);
    $past(wr) && $past(addr) == a && rd && addr == a;
  endsequence
  a_unmapped_zero: assert property (
    rd && !(addr inside {5'h06, 5'h07, 5'h08, 5'h0D, 5'h0E}) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_exp_reserved: assert property (rd && addr == 5'h06 |=> rdata[15:5] == 11'h000)
    else $error("expansion reserved bits set");
  a_np_ro_bit: assert property (rd && addr == 5'h07 |=> !rdata[14])
    else $error("next page bit 14 set");
  a_np_reset: assert property (
    rd && addr == 5'h07 && !w7 |=> (rdata & 16'hF7FF) == 16'h2001)
    else $error("next page reset value");
  a_ctrl_reset: assert property (rd && addr == 5'h0D && !wd |=> rdata == 16'h0000)
    else $error("control reset value");
  a_ctrl_back: assert property (s_wr_rd(5'h0D) |=> rdata == $past(wdata, 2))
    else $error("control readback");
  a_np_back: assert property (
    s_wr_rd(5'h07) |=> (rdata & 16'hB7FF) == ($past(wdata, 2) & 16'hB7FF))
    else $error("next page readback");
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without read");
endmodule

// ==== tb.sv ====
// Purpose: top bench for register block and station
// Assumes: station passes the write strobe straight through and drops the read strobe while write is high
// Notes:   read answer two cycles after the strobe
`timescale 1ns/1ps
module tb
  import an_np_mmd_pkg::*;
;
  logic i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, o_rvalid, o_mmd_wr, o_mmd_rd;
  logic i_pd_fault = 0, i_partner_np_able = 0, i_local_np_able = 1, i_page_received = 0;
  logic i_partner_an_able = 0, i_tx_toggle = 0;
  logic [4:0] i_addr = 0, o_mmd_dev;
  word_t i_wdata = 0, i_partner_page = 0, i_mmd_rdata = 0, ea;
  word_t o_rdata, o_tx_page, o_mmd_addr, o_mmd_wdata, mwd, mwa;
  int n_fail = 0, total_checks = 0, n_mwr = 0, n_mrd = 0;
  mgmt_if mif ();
  an_np_mmd_station an_np_mmd_station_i (.i_clock, .i_rst_n, .i_wr, .i_rd, .i_addr,
    .i_wdata, .o_rdata, .o_rvalid, .mgmt(mif));
  an_np_mmd_regs an_np_mmd_regs_i (.i_clock, .i_rst_n, .mgmt(mif), .i_pd_fault,
    .i_partner_np_able, .i_local_np_able, .i_page_received, .i_partner_an_able, .i_tx_toggle,
    .i_partner_page, .o_tx_page, .o_mmd_dev, .o_mmd_addr, .o_mmd_wdata, .o_mmd_wr,
    .o_mmd_rd, .i_mmd_rdata);
  an_np_mmd_sva an_np_mmd_sva_i (.i_clock, .i_rst_n, .wr(mif.wr), .rd(mif.rd),
    .addr(mif.addr), .wdata(mif.wdata), .rdata(mif.rdata));
  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    n_mwr <= n_mwr + o_mmd_wr;
    n_mrd <= n_mrd + o_mmd_rd;
    if (o_mmd_wr) begin
      mwd <= o_mmd_wdata;
      mwa <= o_mmd_addr;
    end
  end
  // ****
  // access tasks
  // ****
  task automatic cmp(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic r, input logic [4:0] a, input word_t d);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic rd_chk(input logic [4:0] a, input word_t exp);
    int n;
    acc(0, 1, a, 0);
    acc(0, 0, 0, 0);
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (o_rvalid !== 1'b1 && n < 4);
    if (o_rvalid !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t no read answer", $time);
    end
    cmp(o_rdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1;
    rd_chk(5'h07, 16'h2001);
    rd_chk(5'h0D, 16'h0000);
    rd_chk(5'h1F, 16'h0000);
    rd_chk(5'h06, 16'h0004);
    @(posedge i_clock);
    {i_pd_fault, i_page_received, i_partner_np_able, i_partner_an_able} <= 4'hF;
    acc(1, 0, 5'h06, 16'hFFFF);
    {i_pd_fault, i_page_received} <= 2'b00;
    i_partner_page <= 16'h5800;
    rd_chk(5'h06, 16'h001F);
    rd_chk(5'h06, 16'h000D);
    for (int t = 0; t < 2; t++) begin
      acc(1, 0, 5'h08, 16'hFFFF);
      i_tx_toggle <= t[0];
      acc(1, 0, 5'h07, 16'hFFFF);
      rd_chk(5'h07, 16'hB7FF | 16'(t << 11));
      cmp(o_tx_page, 16'hB7FF | 16'(t << 11));
      rd_chk(5'h08, 16'h5000 | 16'((1 - t) << 11));
    end
    acc(1, 0, 5'h0E, 16'h0100);
    acc(1, 0, 5'h0D, 16'h000A);
    rd_chk(5'h0D, 16'h000A);
    cmp(16'(o_mmd_dev), 16'h000A);
    cmp(o_mmd_addr, 16'h0100);
    ea = 16'h0100;
    for (int op = 1; op < 4; op++) begin
      acc(1, 0, 5'h0D, {op[1:0], 14'h000A});
      i_mmd_rdata <= 16'hA5C3 ^ 16'(op);
      acc(1, 0, 5'h0E, 16'h1234 ^ 16'(op));
      rd_chk(5'h0E, 16'hA5C3 ^ 16'(op));
      cmp(mwd, 16'h1234 ^ 16'(op));
      cmp(mwa, ea);
      ea = ea + 16'(op > 1) + 16'(op == 2);
      cmp(o_mmd_addr, ea);
    end
    cmp(16'(n_mwr), 16'h0003);
    cmp(16'(n_mrd), 16'h0003);
    // second reset in mid-run, local next-page ability withdrawn
    @(posedge i_clock);
    i_rst_n <= 0;
    i_local_np_able <= 0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1;
    rd_chk(5'h07, 16'h2801);
    rd_chk(5'h0D, 16'h0000);
    rd_chk(5'h0E, 16'h0000);
    rd_chk(5'h06, 16'h0009);
    tally_and_finish();
  end
endmodule
